// File: hw/pwt_pkg.sv
/*
 * Shared constants and types of the pulse-width trim link: pulse timing,
 * frame layout, function and parameter codes, controller register map.
 * Assumes a single 250 MHz clock on both ends of the link.
 */
`default_nettype none

package pwt_pkg;

    // ==================================================================
    // clock and pulse timing
    localparam int CLK_PERIOD_NS  = 4;
    localparam int ZERO_MIN_NS    = 50;
    localparam int ZERO_MAX_NS    = 10000;
    localparam int ONE_MIN_NS     = 50000;
    localparam int GAP_MIN_NS     = 10000;
    // least times round up, so glitches below the 0-bit minimum never count
    localparam int ZERO_MIN_CYC   = (ZERO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // fixed split point halfway into the undefined band
    localparam int ONE_THRESH_NS  = (ZERO_MAX_NS + ONE_MIN_NS) / 2;
    localparam int ONE_THRESH_CYC = ONE_THRESH_NS / CLK_PERIOD_NS;
    // widths the controller sends, inside the legal windows with margin
    localparam int SEND_ZERO_NS   = 1000;
    localparam int SEND_ONE_NS    = 60000;
    localparam int SEND_GAP_NS    = 20000;
    localparam int SEND_ZERO_CYC  = SEND_ZERO_NS / CLK_PERIOD_NS;
    localparam int SEND_ONE_CYC   = (SEND_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEND_GAP_CYC   = (SEND_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W          = 16;

    // ==================================================================
    // frame layout, first sent bit at the top of the shift register
    localparam int              FRAME_W     = 38;
    localparam logic [11:0]     START_CODE  = 12'h801;
    localparam logic [11:0]     END_CODE    = 12'h7FE;
    localparam logic [1:0]      SEP_CODE    = 2'h2;
    localparam int              START_MSB   = 37;
    localparam int              FUNC_MSB    = 25;
    localparam int              PARAM_MSB   = 23;
    localparam int              SEP_MSB     = 21;
    localparam int              VALUE_MSB   = 19;
    localparam int              END_MSB     = 11;
    localparam int              READ_BITS   = 8;

    localparam logic [1:0]      FN_SENSE    = 2'h0;
    localparam logic [1:0]      FN_SIM      = 2'h1;
    localparam logic [1:0]      FN_PROG     = 2'h2;
    localparam logic [1:0]      FN_READ     = 2'h3;
    localparam logic [1:0]      PAR_GAIN2   = 2'h0;
    localparam logic [1:0]      PAR_GAIN1   = 2'h1;
    localparam logic [1:0]      PAR_OFFSET  = 2'h2;
    localparam logic [1:0]      PAR_MISC    = 2'h3;
    localparam int              MISC_MASTER = 0;
    localparam int              MISC_TEST   = 1;
    localparam int              MISC_PARITY = 2;

    // ==================================================================
    // controller registers over APB
    localparam logic [7:0]      REG_CTRL    = 8'h00;
    localparam logic [7:0]      REG_WORD_LO = 8'h04;
    localparam logic [7:0]      REG_WORD_HI = 8'h08;
    localparam logic [7:0]      REG_STATUS  = 8'h0C;
    localparam int              CTRL_SEND   = 0;
    localparam int              CTRL_READ   = 1;
    localparam int              STAT_BUSY   = 0;
    localparam int              STAT_BYTE   = 8;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_HIGH = 2'b01,
        HS_LOW  = 2'b10
    } pwt_host_state_t;

endpackage

`default_nettype wire

// File: hw/pwt_if.sv
/*
 * The single programming wire and the read-back pin between controller and
 * device. The bench resolves any shared analog use of the read-back pin.
 */
`default_nettype none

interface pwt_if;
    logic serial_pulse_input;
    logic filter_readback_pin;
    logic readback_drive_en;

    modport device (
        input  serial_pulse_input,
        output filter_readback_pin,
        output readback_drive_en
    );
    modport host (
        output serial_pulse_input,
        input  filter_readback_pin,
        input  readback_drive_en
    );
endinterface

`default_nettype wire

// File: hw/pwt_device.sv
/*
 * Device end: pulse-width decoder, 38-bit frame receiver, volatile trim
 * registers, fuse model with blow switch, fuse read-back shifter.
 * Assumes serial_pulse_input is synchronous to clk_i.
 */
// The APB register port and the placing of the registers were decided locally.
`default_nettype none


module pwt_device
    import pwt_pkg::*;
#(
    parameter int ONE_THRESH = ONE_THRESH_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    pwt_if.device           link,
    output logic [2:0]      gain2_o,
    output logic [6:0]      gain1_o,
    output logic [7:0]      offset_o,
    output logic            master_blown_o,
    output logic            test_fuse_o,
    output logic            parity_fuse_o,
    output logic            blow_active_o,
    output logic            read_active_o,
    output logic            frame_ok_o,
    output logic [1:0]      frame_func_o
);

    localparam logic [CNT_W-1:0] MIN_W   = CNT_W'(ZERO_MIN_CYC);
    localparam logic [CNT_W-1:0] THR_W   = CNT_W'(ONE_THRESH);
    localparam logic [CNT_W-1:0] SAT_W   = {CNT_W{1'b1}};
    localparam logic [2:0]       LAST_RD = 3'(READ_BITS - 1);

    // ==================================================================
    // pulse width measurement
    logic                   pin_q_ff;
    logic [CNT_W-1:0]       width_ff;
    logic                   rise;
    logic                   fall;
    logic                   bit_ok;
    logic                   bit_val;

    assign rise    = link.serial_pulse_input & ~pin_q_ff;
    assign fall    = ~link.serial_pulse_input & pin_q_ff;
    assign bit_ok  = fall & (width_ff >= MIN_W);
    assign bit_val = width_ff >= THR_W;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_q_ff <= 1'b0;
        end else begin
            pin_q_ff <= link.serial_pulse_input;
        end
    end

    // counter saturates, so very long 1-bits stay 1-bits
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            width_ff <= '0;
        end else if (rise) begin
            width_ff <= CNT_W'(1);
        end else if (link.serial_pulse_input && width_ff != SAT_W) begin
            width_ff <= width_ff + CNT_W'(1);
        end
    end

    // ==================================================================
    // receive shift register and frame match
    logic [FRAME_W-1:0]     rx_ff;
    logic                   shifted_ff;
    logic                   frame_hit;
    logic                   decode;
    logic [1:0]             func;
    logic [1:0]             param;
    logic [7:0]             value;
    logic                   one_hot;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_ff      <= '0;
            shifted_ff <= 1'b0;
        end else begin
            shifted_ff <= bit_ok;
            if (bit_ok) begin
                rx_ff <= {rx_ff[FRAME_W-2:0], bit_val};
            end
        end
    end

    // tested on every bit, so no word boundary is needed
    assign frame_hit = (rx_ff[START_MSB -: 12] == START_CODE)
                     & (rx_ff[SEP_MSB -: 2] == SEP_CODE)
                     & (rx_ff[END_MSB -: 12] == END_CODE);
    assign decode    = shifted_ff & frame_hit;
    assign func      = rx_ff[FUNC_MSB -: 2];
    assign param     = rx_ff[PARAM_MSB -: 2];
    assign value     = rx_ff[VALUE_MSB -: 8];
    assign one_hot   = (value != 8'h00) && ((value & (value - 8'h01)) == 8'h00);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_ok_o   <= 1'b0;
            frame_func_o <= 2'h0;
        end else begin
            frame_ok_o <= decode;
            if (decode) begin
                frame_func_o <= func;
            end
        end
    end

    // ==================================================================
    // volatile trim registers
    logic [2:0]             gain2_ff;
    logic [6:0]             gain1_ff;
    logic [7:0]             offset_ff;
    logic                   sim_load;

    assign sim_load = decode & (func == FN_SIM) & ~master_blown_o;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain2_ff  <= '0;
            gain1_ff  <= '0;
            offset_ff <= '0;
        end else if (sim_load) begin
            case (param)
                PAR_GAIN2:  gain2_ff  <= value[2:0];
                PAR_GAIN1:  gain1_ff  <= value[6:0];
                PAR_OFFSET: offset_ff <= value;
                default:    gain2_ff  <= gain2_ff;
            endcase
        end
    end

    // ==================================================================
    // fuse model and blow switch
    logic [2:0]             f_gain2_ff;
    logic [6:0]             f_gain1_ff;
    logic [7:0]             f_offset_ff;
    logic [2:0]             f_misc_ff;
    logic                   blow_on;

    // level, not event: drops as soon as a new bit breaks the match
    assign blow_on = frame_hit & (func == FN_PROG) & one_hot
                   & ~master_blown_o;

    // fuses are modelled as flops that start intact at power-up
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            f_gain2_ff  <= '0;
            f_gain1_ff  <= '0;
            f_offset_ff <= '0;
            f_misc_ff   <= '0;
        end else if (blow_on) begin
            case (param)
                PAR_GAIN2:  f_gain2_ff  <= f_gain2_ff | value[2:0];
                PAR_GAIN1:  f_gain1_ff  <= f_gain1_ff | value[6:0];
                PAR_OFFSET: f_offset_ff <= f_offset_ff | value;
                PAR_MISC:   f_misc_ff   <= f_misc_ff | value[2:0];
                default:    f_misc_ff   <= f_misc_ff;
            endcase
        end
    end

    assign master_blown_o = f_misc_ff[MISC_MASTER];
    assign test_fuse_o    = f_misc_ff[MISC_TEST];
    assign parity_fuse_o  = f_misc_ff[MISC_PARITY];
    assign blow_active_o  = blow_on;

    // ==================================================================
    // active parameter selection
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain2_o  <= '0;
            gain1_o  <= '0;
            offset_o <= '0;
        end else if (master_blown_o) begin
            gain2_o  <= f_gain2_ff;
            gain1_o  <= f_gain1_ff;
            offset_o <= f_offset_ff;
        end else begin
            gain2_o  <= gain2_ff;
            gain1_o  <= gain1_ff;
            offset_o <= offset_ff;
        end
    end

    // ==================================================================
    // fuse read-back
    logic [7:0]             rd_sr_ff;
    logic [2:0]             rd_cnt_ff;
    logic [7:0]             rd_src;

    always_comb begin
        case (param)
            PAR_GAIN2:  rd_src = {5'h00, f_gain2_ff};
            PAR_GAIN1:  rd_src = {1'b0, f_gain1_ff};
            PAR_OFFSET: rd_src = f_offset_ff;
            default:    rd_src = {5'h00, f_misc_ff};
        endcase
    end

    // load comes a cycle after the fall that ends the frame, never clashes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_sr_ff      <= '0;
            rd_cnt_ff     <= '0;
            read_active_o <= 1'b0;
        end else if (decode && func == FN_READ) begin
            rd_sr_ff      <= rd_src;
            rd_cnt_ff     <= '0;
            read_active_o <= 1'b1;
        end else if (fall && read_active_o) begin
            if (rd_cnt_ff == LAST_RD) begin
                read_active_o <= 1'b0;
            end else begin
                rd_sr_ff  <= {rd_sr_ff[6:0], 1'b0};
                rd_cnt_ff <= rd_cnt_ff + 3'h1;
            end
        end
    end

    assign link.filter_readback_pin = read_active_o & rd_sr_ff[7];
    assign link.readback_drive_en   = read_active_o;

endmodule

`default_nettype wire

// File: hw/pwt_host.sv
/*
 * Controller end: APB slave registers, pulse generator for 38-bit words,
 * and an eight-pulse read-back sequence sampling the read-back pin.
 * Assumes APB in the clk_i domain and the device on the same clock.
 */
`default_nettype none

module pwt_host
    import pwt_pkg::*;
#(
    parameter int ZERO_CYC = SEND_ZERO_CYC,
    parameter int ONE_CYC  = SEND_ONE_CYC,
    parameter int GAP_CYC  = SEND_GAP_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       psel_i,
    input  wire logic       penable_i,
    input  wire logic       pwrite_i,
    input  wire logic [7:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]     prdata_o,
    output logic            pready_o,
    output logic            pslverr_o,
    pwt_if.host             link
);

    localparam logic [CNT_W-1:0] ZERO_W = CNT_W'(ZERO_CYC - 1);
    localparam logic [CNT_W-1:0] ONE_W  = CNT_W'(ONE_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_W  = CNT_W'(GAP_CYC - 1);

    // ==================================================================
    // register access
    logic [FRAME_W-1:0]     word_ff;
    logic [7:0]             byte_ff;
    logic                   busy;
    logic                   wr;
    logic                   go_send;
    logic                   go_read;
    pwt_host_state_t        state_ff;

    assign busy      = state_ff != HS_IDLE;
    assign pready_o  = psel_i & penable_i;
    assign pslverr_o = 1'b0;
    assign wr        = psel_i & penable_i & pwrite_i;
    assign go_send   = wr & (paddr_i == REG_CTRL) & pwdata_i[CTRL_SEND] & ~busy;
    assign go_read   = wr & (paddr_i == REG_CTRL) & pwdata_i[CTRL_READ]
                     & ~pwdata_i[CTRL_SEND] & ~busy;

    // word is frozen while busy so a frame never changes mid-flight
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_ff <= '0;
        end else if (wr && !busy) begin
            if (paddr_i == REG_WORD_LO) begin
                word_ff[31:0] <= pwdata_i;
            end else if (paddr_i == REG_WORD_HI) begin
                word_ff[FRAME_W-1:32] <= pwdata_i[FRAME_W-33:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= '0;
        end else if (psel_i && !penable_i) begin
            case (paddr_i)
                REG_WORD_LO: prdata_o <= word_ff[31:0];
                REG_WORD_HI: prdata_o <= {26'h0, word_ff[FRAME_W-1:32]};
                REG_STATUS:  prdata_o <= {16'h0, byte_ff, 7'h00, busy};
                default:     prdata_o <= 32'h0;
            endcase
        end
    end

    // ==================================================================
    // pulse sequencer
    logic                   reading_ff;
    logic [5:0]             idx_ff;
    logic [CNT_W-1:0]       timer_ff;
    logic                   last;

    assign last = idx_ff == 6'h00;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff   <= HS_IDLE;
            reading_ff <= 1'b0;
            idx_ff     <= '0;
            timer_ff   <= '0;
        end else begin
            case (state_ff)
                HS_IDLE: begin
                    if (go_send) begin
                        state_ff   <= HS_HIGH;
                        reading_ff <= 1'b0;
                        idx_ff     <= 6'(FRAME_W - 1);
                        timer_ff   <= word_ff[FRAME_W-1] ? ONE_W : ZERO_W;
                    end else if (go_read) begin
                        state_ff   <= HS_HIGH;
                        reading_ff <= 1'b1;
                        idx_ff     <= 6'(READ_BITS - 1);
                        timer_ff   <= ZERO_W;
                    end
                end
                HS_HIGH: begin
                    if (timer_ff == '0) begin
                        state_ff <= HS_LOW;
                        timer_ff <= GAP_W;
                    end else begin
                        timer_ff <= timer_ff - CNT_W'(1);
                    end
                end
                HS_LOW: begin
                    if (timer_ff != '0) begin
                        timer_ff <= timer_ff - CNT_W'(1);
                    end else if (last) begin
                        state_ff <= HS_IDLE;
                    end else begin
                        state_ff <= HS_HIGH;
                        idx_ff   <= idx_ff - 6'h01;
                        timer_ff <= (!reading_ff && word_ff[idx_ff - 6'h01]) ? ONE_W : ZERO_W;
                    end
                end
                default: state_ff <= HS_IDLE;
            endcase
        end
    end

    // sample the presented bit just before each read pulse shifts it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            byte_ff <= '0;
        end else if (go_read) begin
            byte_ff <= {byte_ff[6:0], link.readback_drive_en & link.filter_readback_pin};
        end else if (reading_ff && state_ff == HS_LOW && timer_ff == '0 && !last) begin
            byte_ff <= {byte_ff[6:0], link.readback_drive_en & link.filter_readback_pin};
        end
    end

    assign link.serial_pulse_input = state_ff == HS_HIGH;

endmodule

`default_nettype wire

// File: bench/pwt_link_chk.sv
/*
 * Checker for the trim link: wire timing, read-back pin, frame pulse,
 * blow switch and trim outputs. Assumes one clock and async low reset.
 */
`default_nettype none

module pwt_link_chk (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       serial_pulse_input,
    input wire logic       filter_readback_pin,
    input wire logic       readback_drive_en,
    input wire logic [2:0] gain2_o,
    input wire logic [6:0] gain1_o,
    input wire logic [7:0] offset_o,
    input wire logic       master_blown_o,
    input wire logic       blow_active_o,
    input wire logic       read_active_o,
    input wire logic       frame_ok_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ==================================================================
    // fall cycle seen one clock back, or two clocks back for s_fall_late
    sequence s_fall;
        $past(serial_pulse_input, 2) && !$past(serial_pulse_input);
    endsequence
    sequence s_fall_late;
        $past(serial_pulse_input, 3) && !$past(serial_pulse_input, 2);
    endsequence

    a_gap_low: assert property ($fell(serial_pulse_input) |-> (!serial_pulse_input) [*8])
        else $error("wire high again too soon");
    a_pulse_wide: assert property ($rose(serial_pulse_input) |-> serial_pulse_input [*8])
        else $error("pulse narrower than minimum");
    a_frame_after: assert property (frame_ok_o |-> s_fall_late)
        else $error("frame pulse without a bit two clocks back");
    a_frame_once: assert property (frame_ok_o |=> !frame_ok_o)
        else $error("frame pulse longer than one clock");
    a_pin_quiet: assert property (!readback_drive_en |-> !filter_readback_pin)
        else $error("read-back pin high outside read mode");
    a_drive_mode: assert property (readback_drive_en == read_active_o)
        else $error("pin enable differs from read mode");
    a_pin_shift: assert property ($changed(filter_readback_pin) && readback_drive_en
        && $past(readback_drive_en) |-> s_fall)
        else $error("read-back pin moved without a falling edge");
    a_read_end: assert property ($fell(read_active_o) |-> s_fall)
        else $error("read mode ended without a falling edge");
    a_blow_intact: assert property (blow_active_o |-> !master_blown_o)
        else $error("blow switch closed after lock");
    a_blow_start: assert property ($rose(blow_active_o) |-> s_fall)
        else $error("blow switch closed without a new bit");
    a_blow_stop: assert property ($fell(blow_active_o) && !master_blown_o |-> s_fall)
        else $error("blow switch opened without a new bit");
    a_trim_cause: assert property ($changed({gain2_o, gain1_o, offset_o}) |->
        $past(frame_ok_o) || ($past(master_blown_o) && !$past(master_blown_o, 2)))
        else $error("trim output moved without a frame");
    a_lock_stable: assert property ($past(master_blown_o, 2) |->
        $stable({gain2_o, gain1_o, offset_o}))
        else $error("trim output moved after lock");
endmodule

`default_nettype wire

// File: bench/tb_pulse_width_trim_interface.sv
/*
 * Bench: controller and device joined by the link; words are sent via
 * APB and trim outputs, fuses and read-back are compared.
 * Assumes shortened pulse widths on both ends.
 */
`default_nettype none

module tb_pulse_width_trim_interface;
    import pwt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i;
    logic        rst_n_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic [2:0]  gain2;
    logic [6:0]  gain1;
    logic [7:0]  offset;
    logic        master;
    logic        blow;
    logic        rdact;
    logic        fok;
    logic [1:0]  ffunc;
    logic        tfuse;
    logic        pfuse;
    int          n_errors;
    int          tests_run;

    pwt_if lk ();

    // short widths keep each word between 2300 and 3020 clocks
    pwt_host #(.ZERO_CYC(20), .ONE_CYC(80), .GAP_CYC(20)) u_pwt_host (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(), .link(lk.host));
    pwt_device #(.ONE_THRESH(40)) u_pwt_device (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .link(lk.device), .gain2_o(gain2),
        .gain1_o(gain1), .offset_o(offset), .master_blown_o(master), .test_fuse_o(tfuse),
        .parity_fuse_o(pfuse), .blow_active_o(blow), .read_active_o(rdact),
        .frame_ok_o(fok), .frame_func_o(ffunc));
    pwt_link_chk u_chk (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .serial_pulse_input(lk.serial_pulse_input),
        .filter_readback_pin(lk.filter_readback_pin),
        .readback_drive_en(lk.readback_drive_en), .gain2_o(gain2), .gain1_o(gain1),
        .offset_o(offset), .master_blown_o(master), .blow_active_o(blow),
        .read_active_o(rdact), .frame_ok_o(fok));

    // ==================================================================
    // tasks
    task automatic conclude;
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            conclude();
        end
    endtask

    // polls busy; bounded so a stuck sender ends the run
    task automatic wait_idle;
        int k;
        k = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            k++;
        end while (rd[STAT_BUSY] !== 1'b0 && k < 2000);
        if (k >= 2000) begin
            n_errors++;
            conclude();
        end
        repeat (8) @(posedge clk_i);
    endtask

    task automatic send(input logic [1:0] fn, input logic [1:0] par, input logic [1:0] sep,
                        input logic [7:0] val);
        logic [37:0] w;
        w = {START_CODE, fn, par, sep, val, END_CODE};
        apb(1'b1, REG_WORD_LO, w[31:0]);
        apb(1'b1, REG_WORD_HI, {26'h0, w[37:32]});
        apb(1'b1, REG_CTRL, 32'h1);
        wait_idle();
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // ==================================================================
    // main sequence
    initial begin
        rst_n_i   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        n_errors  = 0;
        tests_run = 0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        check("reset trim", {gain2, gain1, offset, master}, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped read", rd, 32'h0);
        send(FN_SIM, PAR_GAIN2, SEP_CODE, 8'hFF);
        check("gain2", gain2, 32'h7);
        send(FN_SIM, PAR_GAIN1, SEP_CODE, 8'h8B);
        check("gain1", gain1, 32'h0B);
        send(FN_SIM, PAR_OFFSET, SEP_CODE, 8'h40);
        check("offset", offset, 32'h40);
        send(FN_SIM, PAR_MISC, SEP_CODE, 8'h01);
        check("sim misc", {gain2, gain1, offset, master}, {3'h7, 7'h0B, 8'h40, 1'b0});
        check("sim func", ffunc, FN_SIM);
        send(FN_SENSE, PAR_GAIN2, SEP_CODE, 8'h00);
        check("sense word", gain2, 32'h7);
        check("sense func", ffunc, FN_SENSE);
        send(FN_SIM, PAR_GAIN2, 2'h1, 8'h02);
        check("bad separator", gain2, 32'h7);
        send(FN_PROG, PAR_GAIN2, SEP_CODE, 8'h03);
        send(FN_PROG, PAR_OFFSET, SEP_CODE, 8'h04);
        check("fuse hidden", offset, 32'h40);
        send(FN_READ, PAR_OFFSET, SEP_CODE, 8'h00);
        apb(1'b1, REG_CTRL, 32'h2);
        wait_idle();
        check("read-back byte", rd[15:8], 32'h04);
        check("read mode over", rdact, 32'h0);
        send(FN_PROG, PAR_MISC, SEP_CODE, 8'h04);
        check("misc fuses", {tfuse, pfuse, master}, 32'h2);
        send(FN_PROG, PAR_MISC, SEP_CODE, 8'h01);
        check("master fuse", master, 32'h1);
        // two-bit program above must have left gain2 fuses intact
        check("fuse trim", {gain2, gain1, offset}, {3'h0, 7'h00, 8'h04});
        send(FN_SIM, PAR_GAIN2, SEP_CODE, 8'h05);
        check("locked sim", gain2, 32'h0);
        conclude();
    end
endmodule

`default_nettype wire
